// File: dv/spi_master_model.sv
// external serial master driving the slave link in clock mode 0, msb first
`timescale 1ns/1ps
module spi_master_model (
    output spi_buf_pkg::link_in_t link,
    input  wire logic             miso_out,
    input  wire logic             miso_oe
);
    import spi_buf_pkg::*;
    localparam int HALF = 400;
    initial begin
        link.sclk = 1'b0;
        link.device_select_in_n = 1'b1;
        link.mosi = 1'b0;
    end
    // select low with no clocks, as a rival master would drive it
    task automatic pulse_select(input int dur);
        link.device_select_in_n = 1'b0;
        #(dur);
        link.device_select_in_n = 1'b1;
    endtask
    // one framed word; miso taken at each rising sclk, undriven shows as z
    task automatic xfer(input logic [31:0] tx, input int nbits, output logic [31:0] rx);
        rx = 32'h0000_0000;
        #80;
        link.device_select_in_n = 1'b0;
        #(HALF);
        for (int i = nbits - 1; i >= 0; i--) begin
            link.mosi = tx[i];
            #(HALF);
            link.sclk = 1'b1;
            rx = {rx[30:0], miso_oe ? miso_out : 1'bz};
            #(HALF);
            link.sclk = 1'b0;
        end
        // select rises half a period after the last falling clock
        #(HALF);
        link.device_select_in_n = 1'b1;
        // released data line shows the inverse of its last bit
        link.mosi = ~link.mosi;
    endtask
endmodule

// File: dv/spi_status_buffers_test.sv
// self-checking bench for the serial port status and data buffers
`timescale 1ns/1ps
module spi_status_buffers_test;
    import spi_buf_pkg::*;
    logic        clk;
    logic        reset;
    logic        clk_en;
    reg_req_t    reg_req;
    logic [31:0] rd_data;
    link_in_t    link_in;
    logic        miso_out;
    logic        miso_oe;
    logic        dma_tx_write;
    logic [31:0] dma_tx_data;
    logic        dma_rx_ack;
    logic        dma_complete;
    logic        dma_tx_req;
    logic        dma_rx_req;
    logic        port_irq;
    logic        dma_irq;
    int          err_count;
    int          num_checks;
    int          cycles;
    logic [31:0] d0;
    logic [31:0] d1;
    logic [31:0] md;
    logic [31:0] got;
    logic [31:0] v;

    spi_status_buffers DUT (
        .clk          (clk),
        .reset        (reset),
        .clk_en       (clk_en),
        .reg_req      (reg_req),
        .rd_data      (rd_data),
        .link_in      (link_in),
        .miso_out     (miso_out),
        .miso_oe      (miso_oe),
        .dma_tx_write (dma_tx_write),
        .dma_tx_data  (dma_tx_data),
        .dma_rx_ack   (dma_rx_ack),
        .dma_complete (dma_complete),
        .dma_tx_req   (dma_tx_req),
        .dma_rx_req   (dma_rx_req),
        .port_irq     (port_irq),
        .dma_irq      (dma_irq)
    );

    spi_master_model MASTER (
        .link     (link_in),
        .miso_out (miso_out),
        .miso_oe  (miso_oe)
    );

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    function automatic int wl_bits(input int w);
        return (w == 0) ? 8 : (w == 1) ? 16 : 32;
    endfunction
    function automatic logic [31:0] low_bits(input logic [31:0] x, input int n);
        return (n == 32) ? x : x & ((32'h0000_0001 << n) - 32'h0000_0001);
    endfunction

    task automatic complete_run();
        if (err_count == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] seen);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        reg_req.wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_req <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        reg_req.rd <= 1'b0;
        #1 d = rd_data;
    endtask
    task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        rd_reg(a, d);
        chk(name, exp, d);
    endtask
    task automatic run_xfer(input logic [31:0] m, input int n);
        MASTER.xfer(m, n, got);
        repeat (4) @(posedge clk);
    endtask

    // hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            err_count++;
            complete_run();
        end
    end

    initial begin
        reset = 1'b1;
        clk_en = 1'b1;
        reg_req = '0;
        dma_tx_write = 1'b0;
        dma_tx_data = 32'h0000_0000;
        dma_rx_ack = 1'b0;
        dma_complete = 1'b0;
        err_count = 0;
        num_checks = 0;
        cycles = 0;
        void'($urandom(3));
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        rd_chk("status", STATUS_OFF, 32'h0000_0001);
        rd_chk("dma_cfg", DMACFG_OFF, 32'h0000_0000);
        rd_chk("unmapped", 8'h14, 32'h0000_0000);
        wr_reg(STATUS_OFF, 32'hFFFF_FFFF);
        rd_chk("status", STATUS_OFF, 32'h0000_0001);
        chk("port_irq", 32'h0, {31'h0, port_irq});
        for (int w = 0; w < 3; w++) begin
            d0 = $urandom;
            d1 = $urandom;
            md = $urandom;
            wr_reg(CTRL_OFF, 32'h0000_0001 | (32'(w) << CT_WL));
            wr_reg(TXBUF_OFF, d0);
            wr_reg(TXBUF_OFF, d1);
            rd_chk("status", STATUS_OFF, 32'h0000_0009);
            rd_chk("tx_buf", TXBUF_OFF, d1);
            run_xfer(md, wl_bits(w));
            chk("miso", low_bits(d1, wl_bits(w)), got);
            rd_chk("status", STATUS_OFF, 32'h0000_0021);
            rd_chk("rx_buf", RXBUF_OFF, low_bits(md, wl_bits(w)));
            rd_chk("status", STATUS_OFF, 32'h0000_0001);
        end
        // write lands on the shifter load: old word goes out, new one kept
        v = $urandom;
        wr_reg(STATUS_OFF, 32'h0000_0000);
        fork
            run_xfer($urandom, 32);
            begin
                @(posedge clk);
                wr_reg(TXBUF_OFF, v);
            end
        join
        chk("miso", d1, got);
        rd_chk("status", STATUS_OFF, 32'h0000_006D);
        rd_chk("tx_buf", TXBUF_OFF, v);
        rd_reg(RXBUF_OFF, md);
        wr_reg(STATUS_OFF, 32'h0000_0044);
        rd_chk("status", STATUS_OFF, 32'h0000_0009);
        // no new tx data and rx left unread
        d0 = $urandom;
        run_xfer(d0, 32);
        run_xfer(~d0, 32);
        rd_chk("status", STATUS_OFF, 32'h0000_0035);
        chk("port_irq", 32'h1, {31'h0, port_irq});
        wr_reg(STATUS_OFF, 32'h0000_0000);
        rd_chk("status", STATUS_OFF, 32'h0000_0035);
        wr_reg(STATUS_OFF, 32'h0000_0004);
        rd_chk("status", STATUS_OFF, 32'h0000_0031);
        rd_chk("rx_buf", RXBUF_OFF, d0);
        wr_reg(STATUS_OFF, 32'h0000_0010);
        rd_chk("status", STATUS_OFF, 32'h0000_0001);
        chk("port_irq", 32'h0, {31'h0, port_irq});
        // receive dma with zero fill
        wr_reg(CTRL_OFF, 32'h0000_0049);
        wr_reg(DMACFG_OFF, 32'h0000_0007);
        rd_chk("dma_cfg", DMACFG_OFF, 32'h0000_0007);
        d1 = $urandom;
        wr_reg(TXBUF_OFF, d1);
        run_xfer($urandom, 32);
        chk("miso", d1, got);
        rd_chk("tx_buf", TXBUF_OFF, 32'h0000_0000);
        chk("rx_req", 32'h1, {31'h0, dma_rx_req});
        @(posedge clk);
        dma_rx_ack <= 1'b1;
        @(posedge clk);
        dma_rx_ack <= 1'b0;
        rd_chk("status", STATUS_OFF, 32'h0000_0001);
        @(posedge clk);
        dma_complete <= 1'b1;
        @(posedge clk);
        dma_complete <= 1'b0;
        #1 chk("dma_irq", 32'h1, {31'h0, dma_irq});
        // rival master pulls select low
        wr_reg(DMACFG_OFF, 32'h0000_0000);
        wr_reg(CTRL_OFF, 32'h0000_0013);
        MASTER.pulse_select(500);
        repeat (4) @(posedge clk);
        rd_chk("status", STATUS_OFF, 32'h0000_0003);
        rd_chk("control", CTRL_OFF, 32'h0000_0010);
        chk("port_irq", 32'h1, {31'h0, port_irq});
        wr_reg(STATUS_OFF, 32'h0000_0002);
        rd_chk("status", STATUS_OFF, 32'h0000_0001);
        // byte packing
        wr_reg(CTRL_OFF, 32'h0000_0005);
        wr_reg(TXBUF_OFF, $urandom);
        run_xfer($urandom, 8);
        rd_reg(STATUS_OFF, v);
        chk("rx_full", 32'h0, {31'h0, v[ST_RXFULL]});
        run_xfer($urandom, 8);
        rd_reg(STATUS_OFF, v);
        chk("rx_full", 32'h1, {31'h0, v[ST_RXFULL]});
        // transmit dma fills the buffer, no core write
        wr_reg(DMACFG_OFF, 32'h0000_0001);
        repeat (2) @(posedge clk);
        chk("tx_req", 32'h1, {31'h0, dma_tx_req});
        d0 = $urandom;
        @(posedge clk);
        dma_tx_write <= 1'b1;
        dma_tx_data <= d0;
        @(posedge clk);
        dma_tx_write <= 1'b0;
        rd_chk("tx_buf", TXBUF_OFF, d0);
        chk("tx_req", 32'h0, {31'h0, dma_tx_req});
        complete_run();
    end
endmodule

// File: verilog/spi_buf_pkg.sv
// shared constants and carriers for the serial port status and data buffers
package spi_buf_pkg;
    // register byte addresses
    localparam logic [7:0] STATUS_OFF = 8'h00;
    localparam logic [7:0] TXBUF_OFF  = 8'h04;
    localparam logic [7:0] RXBUF_OFF  = 8'h08;
    localparam logic [7:0] DMACFG_OFF = 8'h0C;
    localparam logic [7:0] CTRL_OFF   = 8'h10;
    // port_status bit positions
    localparam int ST_DONE   = 0;
    localparam int ST_FAULT  = 1;
    localparam int ST_UNDER  = 2;
    localparam int ST_TXFULL = 3;
    localparam int ST_OVER   = 4;
    localparam int ST_RXFULL = 5;
    localparam int ST_COLL   = 6;
    // dma_configuration bit positions
    localparam int DC_ON     = 0;
    localparam int DC_DIR    = 1;
    localparam int DC_IRQ    = 2;
    localparam int DC_OVER   = 9;
    localparam int DC_UNDER  = 10;
    localparam int DC_FAULT  = 11;
    // port_control bit positions
    localparam int CT_ENABLE = 0;
    localparam int CT_MASTER = 1;
    localparam int CT_PACK   = 2;
    localparam int CT_ZERO   = 3;
    localparam int CT_DETECT = 4;
    localparam int CT_WL     = 5;
    // reset values
    localparam logic        DONE_RST = 1'b1;
    localparam logic [31:0] WORD_RST = 32'h0000_0000;
    // word length codes and bit counts
    localparam logic [1:0] WL_8  = 2'h0;
    localparam logic [1:0] WL_16 = 2'h1;
    localparam logic [5:0] BITS_8  = 6'h08;
    localparam logic [5:0] BITS_16 = 6'h10;
    localparam logic [5:0] BITS_32 = 6'h20;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } reg_req_t;

    typedef struct packed {
        logic sclk;
        logic device_select_in_n;
        logic mosi;
    } link_in_t;
endpackage

// File: verilog/spi_status_buffers.sv
// serial port status flags, transmit and receive buffers, dma control bits
// How it works
// RQ1: error bits clear only on written one
// RQ2: informational bits follow hardware, ignore writes
// RQ3: transfer done flag resets high, sets at end
// RQ4: master with select low raises mode fault
// RQ5: load without new data flags underrun
// RQ6: tx full sets on write, clears on load
// RQ7: word received while full flags overrun
// RQ8: rx full sets on load, clears on read
// RQ9: write during shifter load flags collision
// RQ10: packing sets rx full after two words
// RQ11: buffer access never stalls, overwrite allowed
// RQ12: tx buffer loads shifter before transfer
// RQ13: software avoids tx writes during tx dma
// RQ14: receive dma resends tx buffer contents
// RQ15: zero fill clears tx buffer after load
// RQ16: last tx write before load is sent
// RQ17: software writes tx only when empty
// RQ18: after underrun write when done falls
// RQ19: rx buffer loads at end, dma reads
// RQ20: dma error copies sticky until new dma
// RQ21: dma enable, direction, irq enable bits
// RQ22: mode fault drops master and enable
// RQ23: any error bit raises port interrupt
// RQ24: packing moves bytes on receive and transmit
// RQ25: reserved status bits read zero
`timescale 1ns/1ps
module spi_status_buffers (
    input  wire logic                  clk,
    input  wire logic                  reset,
    input  wire logic                  clk_en,
    input  wire spi_buf_pkg::reg_req_t reg_req,
    output logic [31:0]                rd_data,
    input  wire spi_buf_pkg::link_in_t link_in,
    output logic                       miso_out,
    output logic                       miso_oe,
    input  wire logic                  dma_tx_write,
    input  wire logic [31:0]           dma_tx_data,
    input  wire logic                  dma_rx_ack,
    input  wire logic                  dma_complete,
    output logic                       dma_tx_req,
    output logic                       dma_rx_req,
    output logic                       port_irq,
    output logic                       dma_irq
);
    import spi_buf_pkg::*;

    typedef struct packed {
        logic [2:0]  sclk_s;
        logic [2:0]  ds_s;
        logic [1:0]  mosi_s;
        logic        done;
        logic        fault;
        logic        under;
        logic        tx_full;
        logic        over;
        logic        rx_full;
        logic        coll;
        logic        port_enable;
        logic        master_select;
        logic        word_packing_on;
        logic        zero_fill_tx;
        logic        detect_on;
        logic [1:0]  wl;
        logic        dma_on;
        logic        dma_direction;
        logic        dma_done_irq_on;
        logic        dma_overrun_sticky;
        logic        dma_underrun_sticky;
        logic        dma_mode_fault_sticky;
        logic [31:0] transmit_buffer;
        logic [31:0] receive_buffer;
        logic [31:0] tx_shifter;
        logic [31:0] rx_shifter;
        logic [5:0]  bit_cnt;
        logic        tx_idx;
        logic        rx_idx;
        logic        miso_oe;
        logic [31:0] rd_data;
        logic        dma_tx_req;
        logic        dma_rx_req;
        logic        port_irq;
        logic        dma_irq;
    } state_t;

    state_t st;
    state_t next_st;
    logic   load_ev;
    logic   word_end;
    logic   fault_ev;
    logic   wr_tx;
    logic   rd_rx;
    logic   errs;

    function automatic logic [5:0] word_bits(input logic [1:0] wl);
        if (wl == WL_8)
            return BITS_8;
        else if (wl == WL_16)
            return BITS_16;
        else
            return BITS_32;
    endfunction

    function automatic logic [31:0] align_msb(input logic [31:0] d, input logic [1:0] wl);
        if (wl == WL_8)
            return {d[7:0], 24'h000000};
        else if (wl == WL_16)
            return {d[15:0], 16'h0000};
        else
            return d;
    endfunction

    always_comb begin
        logic       rise;
        logic       fall;
        logic       sel;
        logic       sel_fall;
        logic       slave_on;
        logic       wr_st;
        logic       wr_dc;
        logic       wr_ct;
        logic [5:0] nbits;
        logic [31:0] src;
        next_st = st;
        rise = st.sclk_s[1] & ~st.sclk_s[2];
        fall = ~st.sclk_s[1] & st.sclk_s[2];
        sel = ~st.ds_s[1];
        sel_fall = ~st.ds_s[1] & st.ds_s[2];
        slave_on = st.port_enable & ~st.master_select;
        nbits = word_bits(st.wl);
        src = 32'h0000_0000;
        wr_st = 1'b0;
        wr_dc = 1'b0;
        wr_ct = 1'b0;
        wr_tx = 1'b0;
        rd_rx = 1'b0;
        load_ev = 1'b0;
        word_end = 1'b0;
        fault_ev = 1'b0;
        next_st.sclk_s = {st.sclk_s[1:0], link_in.sclk};
        next_st.ds_s = {st.ds_s[1:0], link_in.device_select_in_n};
        next_st.mosi_s = {st.mosi_s[0], link_in.mosi};
        if (reg_req.addr == STATUS_OFF)
            wr_st = reg_req.wr;
        else if (reg_req.addr == TXBUF_OFF)
            wr_tx = reg_req.wr;
        else if (reg_req.addr == RXBUF_OFF)
            rd_rx = reg_req.rd;
        else if (reg_req.addr == DMACFG_OFF)
            wr_dc = reg_req.wr;
        else if (reg_req.addr == CTRL_OFF)
            wr_ct = reg_req.wr;
        // write one to clear; zero bits and read-only bits untouched
        if (wr_st) begin
            next_st.fault = st.fault & ~reg_req.wdata[ST_FAULT]; // RQ1 RQ2 RQ25
            next_st.under = st.under & ~reg_req.wdata[ST_UNDER]; // RQ1
            next_st.over = st.over & ~reg_req.wdata[ST_OVER]; // RQ1
            next_st.coll = st.coll & ~reg_req.wdata[ST_COLL]; // RQ1
        end
        if (wr_ct) begin
            next_st.port_enable = reg_req.wdata[CT_ENABLE] & ~next_st.fault; // RQ22
            next_st.master_select = reg_req.wdata[CT_MASTER] & ~next_st.fault; // RQ22
            next_st.word_packing_on = reg_req.wdata[CT_PACK]; // RQ24
            next_st.zero_fill_tx = reg_req.wdata[CT_ZERO];
            next_st.detect_on = reg_req.wdata[CT_DETECT];
            next_st.wl = reg_req.wdata[CT_WL+1:CT_WL];
        end
        if (wr_dc) begin
            next_st.dma_on = reg_req.wdata[DC_ON]; // RQ21
            next_st.dma_direction = reg_req.wdata[DC_DIR]; // RQ21
            next_st.dma_done_irq_on = reg_req.wdata[DC_IRQ]; // RQ21
            if (reg_req.wdata[DC_ON]) begin
                next_st.dma_overrun_sticky = st.dma_overrun_sticky & next_st.over; // RQ20
                next_st.dma_underrun_sticky = st.dma_underrun_sticky & next_st.under; // RQ20
                next_st.dma_mode_fault_sticky = st.dma_mode_fault_sticky & next_st.fault; // RQ20
            end
        end
        if (st.detect_on && st.master_select && st.port_enable && !st.ds_s[1]) begin
            fault_ev = 1'b1;
            next_st.fault = 1'b1; // RQ4
            next_st.port_enable = 1'b0; // RQ22
            next_st.master_select = 1'b0; // RQ22
            if (st.dma_on)
                next_st.dma_mode_fault_sticky = 1'b1; // RQ20
        end
        if (rd_rx || dma_rx_ack)
            next_st.rx_full = 1'b0; // RQ8 RQ19
        if (!(slave_on && sel))
            next_st.bit_cnt = 6'h00;
        else if (sel_fall)
            load_ev = 1'b1; // RQ12 RQ14
        else if (rise) begin
            next_st.rx_shifter = {st.rx_shifter[30:0], st.mosi_s[1]};
            next_st.bit_cnt = st.bit_cnt + 6'h01;
            if (st.bit_cnt + 6'h01 == nbits)
                word_end = 1'b1;
        end else if (fall)
            next_st.tx_shifter = {st.tx_shifter[30:0], 1'b0};
        if (word_end) begin
            next_st.done = 1'b1; // RQ3
            next_st.bit_cnt = 6'h00;
            src = st.word_packing_on ? {st.receive_buffer[23:0], next_st.rx_shifter[7:0]}
                                     : next_st.rx_shifter; // RQ24
            if (st.rx_full) begin
                next_st.over = 1'b1; // RQ7
                if (st.dma_on && st.dma_direction)
                    next_st.dma_overrun_sticky = 1'b1; // RQ20
            end else begin
                next_st.receive_buffer = src; // RQ19
                next_st.rx_idx = st.word_packing_on & ~st.rx_idx;
                if (!st.word_packing_on || st.rx_idx)
                    next_st.rx_full = 1'b1; // RQ8 RQ10
            end
        end
        if (load_ev) begin
            next_st.rx_shifter = WORD_RST;
            if (st.word_packing_on) begin
                src = st.tx_idx ? {24'h000000, st.transmit_buffer[15:8]}
                                : {24'h000000, st.transmit_buffer[7:0]}; // RQ24
                next_st.tx_idx = ~st.tx_idx;
            end else
                src = st.transmit_buffer;
            next_st.tx_shifter = align_msb(src, st.wl); // RQ12
            if (!st.word_packing_on || st.tx_idx) begin
                next_st.done = 1'b0;
                if (!st.tx_full) begin
                    next_st.under = 1'b1; // RQ5
                    if (st.dma_on && !st.dma_direction)
                        next_st.dma_underrun_sticky = 1'b1; // RQ20
                end
                next_st.tx_full = 1'b0; // RQ6
                if (st.zero_fill_tx)
                    next_st.transmit_buffer = WORD_RST; // RQ15
                if (wr_tx)
                    next_st.coll = 1'b1; // RQ9
            end
        end
        // newest write wins over older data and over a load in the same cycle
        if (wr_tx) begin
            next_st.transmit_buffer = reg_req.wdata; // RQ11 RQ16
            next_st.tx_full = 1'b1; // RQ6
        end else if (dma_tx_write && st.dma_on && !st.dma_direction) begin
            next_st.transmit_buffer = dma_tx_data; // RQ13
            next_st.tx_full = 1'b1; // RQ6
        end
        next_st.miso_oe = slave_on & sel;
        next_st.dma_tx_req = st.dma_on & ~st.dma_direction & ~next_st.tx_full;
        next_st.dma_rx_req = st.dma_on & st.dma_direction & next_st.rx_full; // RQ19
        next_st.port_irq = next_st.fault | next_st.under | next_st.over | next_st.coll
                           | next_st.dma_overrun_sticky | next_st.dma_underrun_sticky
                           | next_st.dma_mode_fault_sticky; // RQ23
        next_st.dma_irq = dma_complete & st.dma_done_irq_on; // RQ21
        next_st.rd_data = 32'h0000_0000;
        if (!reg_req.rd)
            next_st.rd_data = 32'h0000_0000;
        else if (reg_req.addr == STATUS_OFF)
            next_st.rd_data = {25'h0000000, st.coll, st.rx_full, st.over, st.tx_full,
                               st.under, st.fault, st.done}; // RQ25
        else if (reg_req.addr == TXBUF_OFF)
            next_st.rd_data = st.transmit_buffer; // RQ12
        else if (reg_req.addr == RXBUF_OFF)
            next_st.rd_data = st.receive_buffer; // RQ11
        else if (reg_req.addr == DMACFG_OFF)
            next_st.rd_data = {20'h00000, st.dma_mode_fault_sticky, st.dma_underrun_sticky,
                               st.dma_overrun_sticky, 6'h00, st.dma_done_irq_on,
                               st.dma_direction, st.dma_on};
        else if (reg_req.addr == CTRL_OFF)
            next_st.rd_data = {25'h0000000, st.wl, st.detect_on, st.zero_fill_tx,
                               st.word_packing_on, st.master_select, st.port_enable};
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            st <= '0;
            st.sclk_s <= 3'h0;
            st.ds_s <= 3'h7;
            st.done <= DONE_RST; // RQ3
            st.transmit_buffer <= WORD_RST;
            st.receive_buffer <= WORD_RST;
        end else if (clk_en) begin
            st <= next_st;
        end
    end

    assign rd_data = st.rd_data;
    assign miso_out = st.tx_shifter[31];
    assign miso_oe = st.miso_oe;
    assign dma_tx_req = st.dma_tx_req;
    assign dma_rx_req = st.dma_rx_req;
    assign port_irq = st.port_irq;
    assign dma_irq = st.dma_irq;
    assign errs = st.fault | st.under | st.over | st.coll;

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence s_full_end;
        clk_en && word_end && st.rx_full && !rd_rx && !dma_rx_ack;
    endsequence

    sequence s_load_write;
        clk_en && load_ev && wr_tx && (!st.word_packing_on || st.tx_idx);
    endsequence

    property p_w1c_zero_keeps;
        clk_en && wr_tx == 1'b0 && reg_req.wr && reg_req.addr == STATUS_OFF
            && !reg_req.wdata[ST_OVER] && st.over |=> st.over;
    endproperty
    a_w1c_zero_keeps: assert property (p_w1c_zero_keeps) else $error("overrun lost on zero write"); // RQ1

    property p_done_at_end;
        clk_en && word_end |=> st.done;
    endproperty
    a_done_at_end: assert property (p_done_at_end) else $error("done flag not set at end"); // RQ3

    property p_pack_first_byte;
        clk_en && word_end && st.word_packing_on && !st.rx_idx && !st.rx_full
            && !rd_rx && !dma_rx_ack |=> !st.rx_full;
    endproperty
    a_pack_first_byte: assert property (p_pack_first_byte) else $error("rx full after one byte"); // RQ10

    property p_load_empties;
        clk_en && load_ev && !wr_tx && !dma_tx_write && !st.word_packing_on |=> !st.tx_full;
    endproperty
    a_load_empties: assert property (p_load_empties) else $error("tx full kept after load"); // RQ6

    property p_fault_blocks_enable;
        clk_en && st.fault |=> !st.port_enable && !st.master_select;
    endproperty
    a_fault_blocks_enable: assert property (p_fault_blocks_enable) else $error("enabled in fault"); // RQ22

    property p_done_clears_on_load;
        clk_en && load_ev && !word_end && !st.word_packing_on |=> !st.done;
    endproperty
    a_done_clears_on_load: assert property (p_done_clears_on_load) else $error("done flag not cleared at load"); // RQ3

    property p_fault_drops;
        clk_en && fault_ev |=> st.fault && !st.port_enable && !st.master_select ##1 port_irq;
    endproperty
    a_fault_drops: assert property (p_fault_drops) else $error("mode fault handling wrong"); // RQ4

    property p_underrun;
        clk_en && load_ev && !st.tx_full && !st.word_packing_on |=> st.under;
    endproperty
    a_underrun: assert property (p_underrun) else $error("underrun not flagged"); // RQ5

    property p_txfull_on_write;
        clk_en && wr_tx |=> st.tx_full && st.transmit_buffer == $past(reg_req.wdata);
    endproperty
    a_txfull_on_write: assert property (p_txfull_on_write) else $error("tx write not held"); // RQ6

    property p_overrun_keeps;
        s_full_end |=> st.over && $stable(st.receive_buffer);
    endproperty
    a_overrun_keeps: assert property (p_overrun_keeps) else $error("overrun handling wrong"); // RQ7

    property p_rx_read_empties;
        clk_en && rd_rx && !word_end |=> !st.rx_full;
    endproperty
    a_rx_read_empties: assert property (p_rx_read_empties) else $error("rx full not cleared"); // RQ8

    property p_collision;
        s_load_write |=> st.coll ##1 port_irq;
    endproperty
    a_collision: assert property (p_collision) else $error("collision not flagged"); // RQ9

    property p_zero_fill;
        clk_en && load_ev && st.zero_fill_tx && !wr_tx && !dma_tx_write
            && !st.word_packing_on |=> st.transmit_buffer == WORD_RST;
    endproperty
    a_zero_fill: assert property (p_zero_fill) else $error("tx buffer not zeroed"); // RQ15

    property p_irq_follows;
        errs |-> port_irq;
    endproperty
    a_irq_follows: assert property (p_irq_follows) else $error("error without interrupt"); // RQ23
endmodule
